// *** inc/canopen_cfg_pkg.sv ***
package canopen_cfg_pkg;

    // register byte addresses
    localparam logic [5:0] ADDR_PROTOCOL_SELECT   = 6'h00;
    localparam logic [5:0] ADDR_NODE_ADDRESS      = 6'h04;
    localparam logic [5:0] ADDR_BIT_RATE_SELECT   = 6'h08;
    localparam logic [5:0] ADDR_BUS_OFF_RECOVERY  = 6'h0C;
    localparam logic [5:0] ADDR_FAULT_ACTION      = 6'h10;
    localparam logic [5:0] ADDR_CONTROLLER_STATE  = 6'h14;
    localparam logic [5:0] ADDR_RX_FRAME_COUNT    = 6'h18;
    localparam logic [5:0] ADDR_TX_FRAME_COUNT    = 6'h1C;
    localparam logic [5:0] ADDR_BUS_OFF_COUNT     = 6'h20;
    localparam logic [5:0] ADDR_OPERATION_MODE    = 6'h24;
    localparam logic [5:0] ADDR_NETWORK_STATE     = 6'h28;
    localparam logic [5:0] ADDR_NODE_STATE        = 6'h2C;
    localparam logic [5:0] ADDR_CONTROL           = 6'h30;
    localparam logic [5:0] ADDR_ERROR_CODE        = 6'h34;

    // control register bits
    localparam int CTRL_APPLY_BIT   = 0;
    localparam int CTRL_RECOVER_BIT = 1;

    // reset values
    localparam logic [7:0] RST_PROTOCOL_SELECT  = 8'h00;
    localparam logic [7:0] RST_NODE_ADDRESS     = 8'h3F;
    localparam logic [7:0] RST_BIT_RATE_SELECT  = 8'h00;
    localparam logic [7:0] RST_BUS_OFF_RECOVERY = 8'h00;
    localparam logic [7:0] RST_FAULT_ACTION     = 8'h01;

    // encodings
    localparam logic [7:0] PROTO_DISABLED  = 8'h00;
    localparam logic [7:0] PROTO_CANOPEN   = 8'h01;
    localparam logic [7:0] PROTO_ALT       = 8'h02;
    localparam logic [7:0] NODE_ADDR_MIN   = 8'h01;
    localparam logic [7:0] NODE_ADDR_MAX   = 8'h7F;
    localparam logic [7:0] RATE_1M         = 8'h00;
    localparam logic [7:0] RATE_UNUSED     = 8'h01;
    localparam logic [7:0] RATE_MAX        = 8'h08;
    localparam logic [7:0] RECOVER_MANUAL  = 8'h00;
    localparam logic [7:0] RECOVER_AUTO    = 8'h01;
    localparam logic [7:0] ACTION_NONE     = 8'h00;
    localparam logic [7:0] ACTION_DISABLE  = 8'h01;

    localparam logic [7:0] CTRL_DISABLED   = 8'h00;
    localparam logic [7:0] CTRL_NO_FAULT   = 8'h02;
    localparam logic [7:0] CTRL_WARNING    = 8'h03;
    localparam logic [7:0] CTRL_PASSIVE    = 8'h04;
    localparam logic [7:0] CTRL_BUS_OFF    = 8'h05;
    localparam logic [7:0] CTRL_NO_SUPPLY  = 8'h06;

    localparam logic [7:0] NET_DISABLED    = 8'h00;
    localparam logic [7:0] NET_ENABLED     = 8'h02;
    localparam logic [7:0] NET_GUARDING    = 8'h03;
    localparam logic [7:0] NET_GUARD_ERR   = 8'h04;

    localparam logic [7:0] MODE_SLAVE      = 8'h00;
    localparam logic [7:0] MODE_MASTER     = 8'h01;

    // communication error codes (decimal 61, 63, 65)
    localparam logic [7:0] ERR_NONE        = 8'h00;
    localparam logic [7:0] ERR_BUS_OFF     = 8'h3D;
    localparam logic [7:0] ERR_NO_SUPPLY   = 8'h3F;
    localparam logic [7:0] ERR_GUARDING    = 8'h41;

    // network management commands
    localparam logic [7:0] NMT_START       = 8'h01;
    localparam logic [7:0] NMT_STOP        = 8'h02;
    localparam logic [7:0] NMT_PREOP       = 8'h80;
    localparam logic [7:0] NMT_RESET_NODE  = 8'h81;
    localparam logic [7:0] NMT_RESET_COMM  = 8'h82;

    // object identifier function codes
    localparam logic [3:0] FUNC_EMCY       = 4'h1;
    localparam logic [3:0] FUNC_SDO_TX     = 4'hB;
    localparam logic [3:0] FUNC_SDO_RX     = 4'hC;
    localparam logic [3:0] FUNC_GUARD      = 4'hE;

    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic [6:0] {
        NODE_INIT    = 7'h00,
        NODE_STOPPED = 7'h04,
        NODE_OPER    = 7'h05,
        NODE_PREOP   = 7'h7F
    } node_state_t;

endpackage

// *** src/canopen_slave_config_status.sv ***
// Function
// - protocol select: 0 off, 1 CANopen, 2 other
// - protocol select applied only at reset
// - node address 1..127, default 63
// - node address applied only at reset
// - node address derives default object identifiers
// - bit rate codes 0..8, 1 unused, default 0
// - bit rate applied only at reset
// - bus off: manual holds, automatic restarts
// - network fault: none or drive disable, default 1
// - error codes 63 supply, 61 bus off, 65 guarding
// - bus off is error only under manual recovery
// - controller state codes 0 to 6
// - 16-bit wrapping received frame counter
// - 16-bit wrapping transmitted frame counter
// - 16-bit wrapping bus off entry counter
// - counters zero after power off
// - counters wrap to zero past maximum
// - operation mode 0 slave, 1 master; slave
// - network state codes 0 to 4
// - enabled only with CANopen and bus supply
// - node state 0, 4, 5, 127
// - node state 0 when disabled or unpowered
// - identifier: 4-bit function, 7-bit address
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module canopen_slave_config_status #(
    parameter int CNT_WIDTH = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic      [1:0]  response,
    output logic             waitrequest,
    input  wire logic        bus_supply_pin,
    input  wire logic        rx_frame_pulse,
    input  wire logic        tx_frame_pulse,
    input  wire logic        bus_off_level,
    input  wire logic        error_warning,
    input  wire logic        error_passive,
    input  wire logic        guard_active,
    input  wire logic        guard_timeout_pulse,
    input  wire logic        nmt_valid,
    input  wire logic [7:0]  nmt_command,
    output logic             can_enable,
    output logic      [7:0]  bit_rate_code,
    output logic      [6:0]  node_id,
    output logic      [10:0] emcy_object_identifier,
    output logic      [10:0] sdo_tx_object_identifier,
    output logic      [10:0] sdo_rx_object_identifier,
    output logic      [10:0] guard_object_identifier,
    output logic             can_restart,
    output logic             drive_disable,
    output logic      [7:0]  comm_error_code
);
    import canopen_cfg_pkg::*;

    if (CNT_WIDTH != 16) begin : g_bad_width
        $error("CNT_WIDTH must be 16");
    end

    typedef struct packed {
        logic                 sup_s1;
        logic                 sup_s2;
        logic                 ack;
        logic [31:0]          rdata;
        logic [1:0]           resp;
        logic [7:0]           proto_sel;
        logic [7:0]           node_addr;
        logic [7:0]           bit_rate;
        logic [7:0]           bo_recov;
        logic [7:0]           fault_act;
        logic [7:0]           act_proto;
        logic [6:0]           act_node;
        logic [7:0]           act_rate;
        node_state_t          node;
        logic [CNT_WIDTH-1:0] rx_cnt;
        logic [CNT_WIDTH-1:0] tx_cnt;
        logic [CNT_WIDTH-1:0] bo_cnt;
        logic                 bus_off_d;
        logic                 sup_d;
        logic                 bo_hold;
        logic                 restart;
        logic [7:0]           err_code;
        logic                 drive_dis;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic       enabled;
    logic [7:0] ctrl_state;
    logic [7:0] net_state;
    logic [7:0] node_code;
    logic       wr_take;
    logic       apply_cfg;
    logic       recover_cmd;
    logic       bo_rise;
    logic       sup_fall;
    logic       err_event;
    logic [7:0] err_new;

    function automatic logic [10:0] make_object_identifier(input logic [3:0] func,
                                                           input logic [6:0] node);
        return {func, node};
    endfunction

    always_comb begin
        enabled = (state_r.act_proto == PROTO_CANOPEN) && state_r.sup_s2;
        if (state_r.act_proto != PROTO_CANOPEN) begin
            ctrl_state = CTRL_DISABLED;
        end else if (!state_r.sup_s2) begin
            ctrl_state = CTRL_NO_SUPPLY;
        end else if (bus_off_level || state_r.bo_hold) begin
            ctrl_state = CTRL_BUS_OFF;
        end else if (error_passive) begin
            ctrl_state = CTRL_PASSIVE;
        end else if (error_warning) begin
            ctrl_state = CTRL_WARNING;
        end else begin
            ctrl_state = CTRL_NO_FAULT;
        end
        if (!enabled) begin
            net_state = NET_DISABLED;
        end else if (state_r.err_code == ERR_GUARDING) begin
            net_state = NET_GUARD_ERR;
        end else if (guard_active) begin
            net_state = NET_GUARDING;
        end else begin
            net_state = NET_ENABLED;
        end
        node_code = {1'b0, state_r.node};
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.sup_s1 = bus_supply_pin;
        state_nxt.sup_s2 = state_r.sup_s1;
        state_nxt.sup_d = state_r.sup_s2;
        state_nxt.bus_off_d = bus_off_level;
        state_nxt.restart = 1'b0;

        // bus slave: one wait cycle, answer on the second
        state_nxt.ack = (read || write) && !state_r.ack;
        wr_take = write && state_r.ack;
        apply_cfg = wr_take && (address == ADDR_CONTROL) && writedata[CTRL_APPLY_BIT];
        recover_cmd = wr_take && (address == ADDR_CONTROL) && writedata[CTRL_RECOVER_BIT];
        if ((read || write) && !state_r.ack) begin
            state_nxt.resp = RESP_OKAY;
            state_nxt.rdata = 32'h0000_0000;
            if (address == ADDR_PROTOCOL_SELECT) begin
                state_nxt.rdata[7:0] = state_r.proto_sel;
            end else if (address == ADDR_NODE_ADDRESS) begin
                state_nxt.rdata[7:0] = state_r.node_addr;
            end else if (address == ADDR_BIT_RATE_SELECT) begin
                state_nxt.rdata[7:0] = state_r.bit_rate;
            end else if (address == ADDR_BUS_OFF_RECOVERY) begin
                state_nxt.rdata[7:0] = state_r.bo_recov;
            end else if (address == ADDR_FAULT_ACTION) begin
                state_nxt.rdata[7:0] = state_r.fault_act;
            end else if (address == ADDR_CONTROLLER_STATE) begin
                state_nxt.rdata[7:0] = ctrl_state;
            end else if (address == ADDR_RX_FRAME_COUNT) begin
                state_nxt.rdata[15:0] = state_r.rx_cnt;
            end else if (address == ADDR_TX_FRAME_COUNT) begin
                state_nxt.rdata[15:0] = state_r.tx_cnt;
            end else if (address == ADDR_BUS_OFF_COUNT) begin
                state_nxt.rdata[15:0] = state_r.bo_cnt;
            end else if (address == ADDR_OPERATION_MODE) begin
                state_nxt.rdata[7:0] = MODE_SLAVE;
            end else if (address == ADDR_NETWORK_STATE) begin
                state_nxt.rdata[7:0] = net_state;
            end else if (address == ADDR_NODE_STATE) begin
                state_nxt.rdata[7:0] = node_code;
            end else if (address == ADDR_CONTROL) begin
                state_nxt.rdata = 32'h0000_0000;
            end else if (address == ADDR_ERROR_CODE) begin
                state_nxt.rdata[7:0] = state_r.err_code;
            end else begin
                state_nxt.resp = RESP_SLVERR;
            end
        end

        // stored settings; read-only addresses take no write
        if (wr_take) begin
            if (address == ADDR_PROTOCOL_SELECT) begin
                if (writedata[7:0] <= PROTO_ALT) begin
                    state_nxt.proto_sel = writedata[7:0];
                end
            end else if (address == ADDR_NODE_ADDRESS) begin
                if (writedata[7:0] >= NODE_ADDR_MIN && writedata[7:0] <= NODE_ADDR_MAX) begin
                    state_nxt.node_addr = writedata[7:0];
                end
            end else if (address == ADDR_BIT_RATE_SELECT) begin
                if (writedata[7:0] <= RATE_MAX && writedata[7:0] != RATE_UNUSED) begin
                    state_nxt.bit_rate = writedata[7:0];
                end
            end else if (address == ADDR_BUS_OFF_RECOVERY) begin
                if (writedata[7:0] <= RECOVER_AUTO) begin
                    state_nxt.bo_recov = writedata[7:0];
                end
            end else if (address == ADDR_FAULT_ACTION) begin
                if (writedata[7:0] <= ACTION_DISABLE) begin
                    state_nxt.fault_act = writedata[7:0];
                end
            end
        end

        // board reset: stored settings become live
        if (apply_cfg) begin
            state_nxt.act_proto = state_r.proto_sel;
            state_nxt.act_node = state_r.node_addr[6:0];
            state_nxt.act_rate = state_r.bit_rate;
            state_nxt.bo_hold = 1'b0;
            state_nxt.err_code = ERR_NONE;
            state_nxt.drive_dis = 1'b0;
            state_nxt.restart = 1'b1;
        end
        if (recover_cmd && state_r.bo_hold) begin
            state_nxt.bo_hold = 1'b0;
            state_nxt.restart = 1'b1;
        end

        // counters wrap by natural overflow
        if (rx_frame_pulse) begin
            state_nxt.rx_cnt = state_r.rx_cnt + 16'h0001;
        end
        if (tx_frame_pulse) begin
            state_nxt.tx_cnt = state_r.tx_cnt + 16'h0001;
        end
        bo_rise = bus_off_level && !state_r.bus_off_d;
        if (bo_rise) begin
            state_nxt.bo_cnt = state_r.bo_cnt + 16'h0001;
        end

        // communication errors; a new event wins over a clear
        sup_fall = state_r.sup_d && !state_r.sup_s2;
        err_event = 1'b0;
        err_new = ERR_NONE;
        if (state_r.act_proto == PROTO_CANOPEN) begin
            if (bo_rise && state_r.bo_recov == RECOVER_MANUAL) begin
                err_event = 1'b1;
                err_new = ERR_BUS_OFF;
            end
            if (guard_timeout_pulse && enabled) begin
                err_event = 1'b1;
                err_new = ERR_GUARDING;
            end
            if (sup_fall) begin
                err_event = 1'b1;
                err_new = ERR_NO_SUPPLY;
            end
        end
        if (bo_rise) begin
            if (state_r.bo_recov == RECOVER_AUTO) begin
                state_nxt.restart = 1'b1;
            end else begin
                state_nxt.bo_hold = 1'b1;
                state_nxt.restart = 1'b0;
            end
        end
        if (err_event) begin
            state_nxt.err_code = err_new;
            if (state_r.fault_act == ACTION_DISABLE) begin
                state_nxt.drive_dis = 1'b1;
            end
        end

        // slave node state machine
        if (!enabled || apply_cfg) begin
            state_nxt.node = NODE_INIT;
        end else begin
            case (state_r.node)
                NODE_INIT: begin
                    state_nxt.node = NODE_PREOP;
                end
                default: begin
                    if (nmt_valid) begin
                        case (nmt_command)
                            NMT_START: begin
                                state_nxt.node = NODE_OPER;
                            end
                            NMT_STOP: begin
                                state_nxt.node = NODE_STOPPED;
                            end
                            NMT_PREOP: begin
                                state_nxt.node = NODE_PREOP;
                            end
                            NMT_RESET_NODE, NMT_RESET_COMM: begin
                                state_nxt.node = NODE_INIT;
                            end
                            default: begin
                                state_nxt.node = state_r.node;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= '{
                sup_s1: 1'b0, sup_s2: 1'b0, ack: 1'b0, rdata: 32'h0000_0000, resp: RESP_OKAY,
                proto_sel: RST_PROTOCOL_SELECT, node_addr: RST_NODE_ADDRESS,
                bit_rate: RST_BIT_RATE_SELECT, bo_recov: RST_BUS_OFF_RECOVERY,
                fault_act: RST_FAULT_ACTION, act_proto: RST_PROTOCOL_SELECT,
                act_node: RST_NODE_ADDRESS[6:0], act_rate: RST_BIT_RATE_SELECT,
                node: NODE_INIT, rx_cnt: 16'h0000, tx_cnt: 16'h0000, bo_cnt: 16'h0000,
                bus_off_d: 1'b0, sup_d: 1'b0, bo_hold: 1'b0, restart: 1'b0,
                err_code: ERR_NONE, drive_dis: 1'b0
            };
        end else begin
            state_r <= state_nxt;
        end
    end

    assign waitrequest = (read || write) && !state_r.ack;
    assign readdata = state_r.rdata;
    assign response = state_r.resp;
    assign can_enable = enabled;
    assign bit_rate_code = state_r.act_rate;
    assign node_id = state_r.act_node;
    assign emcy_object_identifier = make_object_identifier(FUNC_EMCY, state_r.act_node);
    assign sdo_tx_object_identifier = make_object_identifier(FUNC_SDO_TX, state_r.act_node);
    assign sdo_rx_object_identifier = make_object_identifier(FUNC_SDO_RX, state_r.act_node);
    assign guard_object_identifier = make_object_identifier(FUNC_GUARD, state_r.act_node);
    assign can_restart = state_r.restart;
    assign drive_disable = state_r.drive_dis;
    assign comm_error_code = state_r.err_code;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence wr_addr_s(logic [5:0] a);
        write && !waitrequest && address == a;
    endsequence

    proto_live_hold_a: assert property (
        wr_addr_s(ADDR_PROTOCOL_SELECT) ##0 !apply_cfg |=> $stable(state_r.act_proto))
        else $error("protocol select became live without reset");
    node_addr_range_a: assert property (
        state_r.node_addr >= NODE_ADDR_MIN && state_r.node_addr <= NODE_ADDR_MAX)
        else $error("stored node address out of range");
    node_apply_a: assert property (
        apply_cfg |=> node_id == $past(state_r.node_addr[6:0]))
        else $error("node address not applied at board reset");
    rate_valid_a: assert property (
        state_r.bit_rate <= RATE_MAX && state_r.bit_rate != RATE_UNUSED)
        else $error("bit rate code invalid");
    auto_restart_a: assert property (
        bus_off_level && !state_r.bus_off_d && state_r.bo_recov == RECOVER_AUTO
        |=> can_restart && !state_r.bo_hold)
        else $error("automatic recovery did not restart");
    drive_off_a: assert property (
        err_event && state_r.fault_act == ACTION_DISABLE |=> drive_disable)
        else $error("drive not disabled on fault");
    bo_error_a: assert property (
        bo_rise && state_r.bo_recov == RECOVER_AUTO && !sup_fall && !guard_timeout_pulse
        && !apply_cfg |=> $stable(comm_error_code))
        else $error("bus off raised error under automatic recovery");
    rx_count_a: assert property (
        rx_frame_pulse |=> state_r.rx_cnt == $past(state_r.rx_cnt) + 16'h0001)
        else $error("received count not incremented");
    bo_count_a: assert property (
        !bo_rise |=> $stable(state_r.bo_cnt))
        else $error("bus off count moved without bus off entry");
    node_zero_a: assert property (
        !enabled |=> node_code == 8'h00 || enabled)
        else $error("node state not zero while disabled");
    ro_write_a: assert property (
        wr_addr_s(ADDR_TX_FRAME_COUNT) ##0 !tx_frame_pulse |=> $stable(state_r.tx_cnt))
        else $error("write altered read-only counter");
    ident_a: assert property (
        guard_object_identifier[6:0] == node_id && guard_object_identifier[10:7] == FUNC_GUARD)
        else $error("guard identifier layout wrong");
endmodule

// *** sim/can_bus_model.sv ***
`timescale 1ns/1ps
module can_bus_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic supply_on,
    input  wire logic rx_req,
    input  wire logic tx_req,
    input  wire logic off_req,
    input  wire logic can_restart,
    output logic      bus_supply_pin,
    output logic      rx_frame_pulse,
    output logic      tx_frame_pulse,
    output logic      bus_off_level
);
    // frame traffic, one pulse per cycle held
    assign bus_supply_pin = supply_on;
    assign rx_frame_pulse = rx_req;
    assign tx_frame_pulse = tx_req;
    // bus off holds until the interface restarts the engine
    always_ff @(posedge sys_clk) begin
        if (rst || (can_restart && !off_req))
            bus_off_level <= 1'b0;
        else if (off_req)
            bus_off_level <= 1'b1;
    end
endmodule

// *** sim/canopen_slave_config_status_tb.sv ***
`timescale 1ns/1ps
module canopen_slave_config_status_tb;
    import canopen_cfg_pkg::*;
    localparam int CW = 16;
    localparam logic [7:0] DEF [12] = '{8'h00, 8'h3F, 8'h00, 8'h00, 8'h01, 8'h00,
                                        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] NMT_C [3] = '{NMT_START, NMT_STOP, NMT_PREOP};
    localparam logic [7:0] NMT_E [3] = '{8'h05, 8'h04, 8'h7F};
    logic        sys_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic [5:0]  address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [1:0]  response, rsp;
    logic        waitrequest, can_enable, can_restart, drive_disable, bus_supply_pin;
    logic        supply_on = 1'b1, rx_req = 1'b0, tx_req = 1'b0, off_req = 1'b0;
    logic        rx_frame_pulse, tx_frame_pulse, bus_off_level;
    logic        error_warning = 1'b0, error_passive = 1'b0, guard_active = 1'b0;
    logic        guard_timeout_pulse = 1'b0, nmt_valid = 1'b0;
    logic [7:0]  nmt_command = 8'h00, bit_rate_code, comm_error_code;
    logic [6:0]  node_id;
    logic [10:0] emcy_object_identifier, sdo_tx_object_identifier;
    logic [10:0] sdo_rx_object_identifier, guard_object_identifier;
    int          bad_count = 0, checks_done = 0, cycles = 0;

    canopen_slave_config_status #(.CNT_WIDTH(CW)) dut (.sys_clk, .rst, .address, .read,
        .write, .writedata, .readdata, .response, .waitrequest, .bus_supply_pin,
        .rx_frame_pulse, .tx_frame_pulse, .bus_off_level, .error_warning, .error_passive,
        .guard_active, .guard_timeout_pulse, .nmt_valid, .nmt_command, .can_enable,
        .bit_rate_code, .node_id, .emcy_object_identifier, .sdo_tx_object_identifier,
        .sdo_rx_object_identifier, .guard_object_identifier, .can_restart, .drive_disable,
        .comm_error_code);
    can_bus_model far (.sys_clk, .rst, .supply_on, .rx_req, .tx_req, .off_req, .can_restart,
        .bus_supply_pin, .rx_frame_pulse, .tx_frame_pulse, .bus_off_level);

    initial forever #4 sys_clk = ~sys_clk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            bad_count = bad_count + 1;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic access(input logic wr_n, input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr_n;
        read <= ~wr_n;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        rd = readdata;
        rsp = response;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        access(1'b1, a, d);
    endtask

    task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic apply();
        wr(ADDR_CONTROL, 32'h1 << CTRL_APPLY_BIT);
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic defaults();
        for (int i = 0; i < 12; i++) begin
            rdc("default", 6'(i * 4), {24'h0, DEF[i]});
        end
        check("can_enable", {31'h0, can_enable}, 32'h0);
        check("node_id", {25'h0, node_id}, 32'h3F);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        defaults();
        for (int v = 0; v < 4; v++) begin
            wr(ADDR_PROTOCOL_SELECT, v);
            rdc("protocol", ADDR_PROTOCOL_SELECT, v < 3 ? v : 2);
        end
        wr(ADDR_PROTOCOL_SELECT, 1);
        for (int v = 0; v < 10; v++) begin
            wr(ADDR_BIT_RATE_SELECT, v);
            rdc("rate", ADDR_BIT_RATE_SELECT, v == 1 ? 0 : (v > 8 ? 8 : v));
        end
        wr(ADDR_NODE_ADDRESS, 127);
        rdc("node max", ADDR_NODE_ADDRESS, 127);
        wr(ADDR_NODE_ADDRESS, 5);
        wr(ADDR_NODE_ADDRESS, 0);
        wr(ADDR_NODE_ADDRESS, 128);
        rdc("node range", ADDR_NODE_ADDRESS, 5);
        check("live node", {25'h0, node_id}, 32'h3F);
        check("live rate", {24'h0, bit_rate_code}, 32'h0);
        check("live proto", {31'h0, can_enable}, 32'h0);
        apply();
        check("node", {25'h0, node_id}, 32'h5);
        check("rate", {24'h0, bit_rate_code}, 32'h8);
        check("enable", {31'h0, can_enable}, 32'h1);
        check("emcy", {21'h0, emcy_object_identifier}, 32'h085);
        check("sdo tx", {21'h0, sdo_tx_object_identifier}, 32'h585);
        check("sdo rx", {21'h0, sdo_rx_object_identifier}, 32'h605);
        check("guard id", {21'h0, guard_object_identifier}, 32'h705);
        rdc("node state", ADDR_NODE_STATE, 8'h7F);
        rdc("network", ADDR_NETWORK_STATE, 2);
        rdc("controller", ADDR_CONTROLLER_STATE, 2);
        for (int i = 0; i < 3; i++) begin
            nmt_command <= NMT_C[i];
            nmt_valid <= 1'b1;
            @(posedge sys_clk);
            nmt_valid <= 1'b0;
            rdc("nmt", ADDR_NODE_STATE, NMT_E[i]);
        end
        error_warning <= 1'b1;
        rdc("warning", ADDR_CONTROLLER_STATE, 3);
        error_passive <= 1'b1;
        rdc("passive", ADDR_CONTROLLER_STATE, 4);
        error_warning <= 1'b0;
        error_passive <= 1'b0;
        guard_active <= 1'b1;
        rdc("guarding", ADDR_NETWORK_STATE, 3);
        guard_timeout_pulse <= 1'b1;
        @(posedge sys_clk);
        guard_timeout_pulse <= 1'b0;
        rdc("guard err", ADDR_ERROR_CODE, 8'h41);
        rdc("guard net", ADDR_NETWORK_STATE, 4);
        check("disable", {31'h0, drive_disable}, 32'h1);
        guard_active <= 1'b0;
        apply();
        check("disable clr", {31'h0, drive_disable}, 32'h0);
        off_req <= 1'b1;
        @(posedge sys_clk);
        off_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rdc("off count", ADDR_BUS_OFF_COUNT, 1);
        rdc("off state", ADDR_CONTROLLER_STATE, 5);
        rdc("off err", ADDR_ERROR_CODE, 8'h3D);
        check("err pin", {24'h0, comm_error_code}, 32'h3D);
        check("held", {31'h0, bus_off_level}, 32'h1);
        wr(ADDR_CONTROL, 32'h1 << CTRL_RECOVER_BIT);
        repeat (2) @(posedge sys_clk);
        check("recovered", {31'h0, bus_off_level}, 32'h0);
        wr(ADDR_BUS_OFF_RECOVERY, 1);
        apply();
        off_req <= 1'b1;
        @(posedge sys_clk);
        off_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("auto", {31'h0, bus_off_level}, 32'h0);
        rdc("auto err", ADDR_ERROR_CODE, 0);
        rdc("off count", ADDR_BUS_OFF_COUNT, 2);
        rx_req <= 1'b1;
        repeat (2 ** CW + 1) @(posedge sys_clk);
        rx_req <= 1'b0;
        tx_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        tx_req <= 1'b0;
        rdc("rx wrap", ADDR_RX_FRAME_COUNT, 1);
        rdc("tx", ADDR_TX_FRAME_COUNT, 2);
        wr(ADDR_TX_FRAME_COUNT, 32'hFFFF);
        wr(ADDR_NODE_STATE, 32'hFF);
        rdc("ro tx", ADDR_TX_FRAME_COUNT, 2);
        rdc("ro node", ADDR_NODE_STATE, 8'h7F);
        rdc("unmapped", 6'h38, 0);
        check("resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(ADDR_FAULT_ACTION, 0);
        apply();
        supply_on <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rdc("no supply", ADDR_CONTROLLER_STATE, 6);
        rdc("supply err", ADDR_ERROR_CODE, 8'h3F);
        rdc("node off", ADDR_NODE_STATE, 0);
        rdc("net off", ADDR_NETWORK_STATE, 0);
        check("enable off", {31'h0, can_enable}, 32'h0);
        check("no action", {31'h0, drive_disable}, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        supply_on <= 1'b1;
        @(posedge sys_clk);
        defaults();
        stop_test();
    end
endmodule
